// file: timer_ch34_pkg.sv
// Function
// - ch4 select: 00 output, 01 input from input four, 10 from input three.
// - ch3 select: 00 output, 01 input from input three, 10 from input four.
// - select 11 maps capture input to internal trigger, only while trigger select is internal.
// - select field written only while that channel's enable bit is clear.
// - ch4 output fields: clear 15, mode 14:12, preload 11, fast 10, select 9:8.
// - ch3 output fields: clear 7, mode 6:4, preload 3, fast 2, select 1:0.
// - input mode: ch4 filter 15:12, prescale 11:10; ch3 filter 7:4, prescale 3:2.
// - mode register at 0x1C, resets to zero: both channels outputs, options off.
// - prescale 00/01/10/11 captures every 1st, 2nd, 4th, 8th edge.
// - prescale counter cleared while channel enable is zero.
// - filter flips output after N agreeing samples; rate and N from filter code.
package timer_ch34_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] mode_offset = 12'h01C;
  localparam logic [11:0] enable_offset = 12'h020;
  localparam logic [11:0] status_offset = 12'h040;
  localparam logic [15:0] mode_reset = 16'h0000;
  localparam logic [1:0] enable_reset = 2'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int chan_byte = 8;
  localparam int sel_lsb = 0;
  localparam int fast_pos = 2;
  localparam int preload_pos = 3;
  localparam int cmode_lsb = 4;
  localparam int clear_pos = 7;
  localparam int psc_lsb = 2;
  localparam int filt_lsb = 4;
  localparam int en_pos_ch3 = 8;
  localparam int en_pos_ch4 = 12;

  // selection codes
  localparam logic [1:0] sel_output = 2'h0;
  localparam logic [1:0] sel_own = 2'h1;
  localparam logic [1:0] sel_other = 2'h2;
  localparam logic [1:0] sel_trigger = 2'h3;

  // decoded per-channel configuration
  typedef struct packed {
    logic clear_enable;
    logic [2:0] compare_mode;
    logic preload_enable;
    logic fast_enable;
    logic [3:0] input_filter;
    logic [1:0] capture_prescale;
    logic [1:0] direction_select;
  } ch_cfg_t;

  // filter code to {log2 of sample divider, agreeing samples}
  function automatic logic [6:0] filter_setting(input logic [3:0] code);
    logic [6:0] r;
    r = 7'h01;
    unique case (code)
      4'h0: r = {3'h0, 4'h1};
      4'h1: r = {3'h0, 4'h2};
      4'h2: r = {3'h0, 4'h4};
      4'h3: r = {3'h0, 4'h8};
      4'h4: r = {3'h1, 4'h6};
      4'h5: r = {3'h1, 4'h8};
      4'h6: r = {3'h2, 4'h6};
      4'h7: r = {3'h2, 4'h8};
      4'h8: r = {3'h3, 4'h6};
      4'h9: r = {3'h3, 4'h8};
      4'hA: r = {3'h4, 4'h5};
      4'hB: r = {3'h4, 4'h6};
      4'hC: r = {3'h4, 4'h8};
      4'hD: r = {3'h5, 4'h5};
      4'hE: r = {3'h5, 4'h6};
      4'hF: r = {3'h5, 4'h8};
    endcase
    return r;
  endfunction

endpackage

// file: timer_ch34_mode_config.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module timer_ch34_mode_config (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic reset, // sync, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic timer_input_three, // pin, async
  input wire logic timer_input_four, // pin, async
  input wire logic internal_trigger_signal, // same clock
  input wire logic trigger_source_select_internal, // selector picks internal
  output timer_ch34_pkg::ch_cfg_t ch3_config, // decoded ch3 controls
  output timer_ch34_pkg::ch_cfg_t ch4_config, // decoded ch4 controls
  output logic ch3_capture_input, // filtered ch3 input
  output logic ch4_capture_input, // filtered ch4 input
  output logic ch3_capture_event, // ch3 capture pulse
  output logic ch4_capture_event, // ch4 capture pulse
  output logic ch3_channel_enable, // ch3 enable bit
  output logic ch4_channel_enable // ch4 enable bit
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [15:0] next_mode_reg;
  logic [1:0] enable_reg;
  logic [1:0] next_enable_reg;
  logic pready_q, next_pready;
  logic pslverr_q, next_pslverr;
  logic [31:0] prdata_q, next_prdata;
  logic [1:0] sync_a, sync_b;
  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic [1:0] level;
  logic [1:0] cap_evt;
  logic [5:0] psc_view;
  logic access, wr;
  logic [11:0] status_bits;

  assign access = psel & penable;
  assign wr = access & pwrite & pready_q;

  // pin synchronisers, two stages each
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= {timer_input_four, timer_input_three};
      sync_b <= sync_a;
    end
  end

  // free-running sample divider
  always_comb begin
    next_div_cnt = div_cnt + 5'h01;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, then ready with data
  // ---------------------------------------------------------------
  assign status_bits = {psc_view, 2'h0, cap_evt, level};

  always_comb begin
    next_mode_reg = mode_reg;
    next_enable_reg = enable_reg;
    next_pready = access & ~pready_q;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (access & ~pready_q) begin
      unique case (paddr)
        timer_ch34_pkg::mode_offset: next_prdata = {16'h0000, mode_reg};
        timer_ch34_pkg::enable_offset: begin
          next_prdata[timer_ch34_pkg::en_pos_ch3] = enable_reg[0];
          next_prdata[timer_ch34_pkg::en_pos_ch4] = enable_reg[1];
        end
        timer_ch34_pkg::status_offset: next_prdata = {20'h0_0000, status_bits};
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end
    end
    if (wr && paddr == timer_ch34_pkg::mode_offset) begin
      for (int i = 0; i < 2; i++) begin
        // upper six bits of the byte are always writable
        next_mode_reg[i*timer_ch34_pkg::chan_byte + 2 +: 6] =
          pwdata[i*timer_ch34_pkg::chan_byte + 2 +: 6];
        if (!enable_reg[i]) begin
          next_mode_reg[i*timer_ch34_pkg::chan_byte + timer_ch34_pkg::sel_lsb +: 2] =
            pwdata[i*timer_ch34_pkg::chan_byte + timer_ch34_pkg::sel_lsb +: 2];
        end
      end
    end
    if (wr && paddr == timer_ch34_pkg::enable_offset) begin
      next_enable_reg = {pwdata[timer_ch34_pkg::en_pos_ch4], pwdata[timer_ch34_pkg::en_pos_ch3]};
    end
  end

  // bus and register flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg <= timer_ch34_pkg::mode_reset;
      enable_reg <= timer_ch34_pkg::enable_reset;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      mode_reg <= next_mode_reg;
      enable_reg <= next_enable_reg;
      pready_q <= next_pready;
      pslverr_q <= next_pslverr;
      prdata_q <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // channels: index 0 is ch3, index 1 is ch4
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : chan
    logic [7:0] cb;
    logic [1:0] sel;
    logic raw;
    logic [6:0] fset;
    logic sample_en;
    logic filt_out, next_filt_out, filt_prev;
    logic [3:0] filt_cnt, next_filt_cnt;
    logic [2:0] psc_cnt, next_psc_cnt;
    logic [2:0] psc_limit;
    logic cap, next_cap;
    timer_ch34_pkg::ch_cfg_t cfg, next_cfg;

    assign cb = mode_reg[i*timer_ch34_pkg::chan_byte +: 8];
    assign sel = cb[timer_ch34_pkg::sel_lsb +: 2];
    assign fset = timer_ch34_pkg::filter_setting(cb[timer_ch34_pkg::filt_lsb +: 4]);
    assign sample_en = (div_cnt & 5'((6'h01 << fset[6:4]) - 6'h01)) == 5'h00;
    assign psc_limit = 3'((4'h1 << cb[timer_ch34_pkg::psc_lsb +: 2]) - 4'h1);

    // capture input routing
    always_comb begin
      raw = 1'b0;
      unique case (sel)
        timer_ch34_pkg::sel_own: raw = sync_b[i];
        timer_ch34_pkg::sel_other: raw = sync_b[1-i];
        timer_ch34_pkg::sel_trigger:
          raw = internal_trigger_signal & trigger_source_select_internal;
        default: raw = 1'b0;
      endcase
    end

    // digital filter, prescaler and control decode
    always_comb begin
      next_filt_out = filt_out;
      next_filt_cnt = filt_cnt;
      next_psc_cnt = psc_cnt;
      next_cap = 1'b0;
      next_cfg = '0;
      if (sel == timer_ch34_pkg::sel_output) begin
        next_filt_out = 1'b0;
        next_filt_cnt = 4'h0;
      end else if (sample_en) begin
        if (raw == filt_out) begin
          next_filt_cnt = 4'h0;
        end else if (filt_cnt + 4'h1 >= fset[3:0]) begin
          next_filt_out = raw;
          next_filt_cnt = 4'h0;
        end else begin
          next_filt_cnt = filt_cnt + 4'h1;
        end
      end
      if (!enable_reg[i] || sel == timer_ch34_pkg::sel_output) begin
        next_psc_cnt = 3'h0;
      end else if (filt_out & ~filt_prev) begin
        if (psc_cnt == psc_limit) begin
          next_cap = 1'b1;
          next_psc_cnt = 3'h0;
        end else begin
          next_psc_cnt = psc_cnt + 3'h1;
        end
      end
      next_cfg.direction_select = sel;
      if (sel == timer_ch34_pkg::sel_output) begin
        next_cfg.clear_enable = cb[timer_ch34_pkg::clear_pos];
        next_cfg.compare_mode = cb[timer_ch34_pkg::cmode_lsb +: 3];
        next_cfg.preload_enable = cb[timer_ch34_pkg::preload_pos];
        next_cfg.fast_enable = cb[timer_ch34_pkg::fast_pos];
      end else begin
        next_cfg.input_filter = cb[timer_ch34_pkg::filt_lsb +: 4];
        next_cfg.capture_prescale = cb[timer_ch34_pkg::psc_lsb +: 2];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        filt_out <= 1'b0;
        filt_prev <= 1'b0;
        filt_cnt <= 4'h0;
        psc_cnt <= 3'h0;
        cap <= 1'b0;
        cfg <= '0;
      end else begin
        filt_out <= next_filt_out;
        filt_prev <= filt_out;
        filt_cnt <= next_filt_cnt;
        psc_cnt <= next_psc_cnt;
        cap <= next_cap;
        cfg <= next_cfg;
      end
    end

    assign level[i] = filt_out;
    assign cap_evt[i] = cap;
    assign psc_view[i*3 +: 3] = psc_cnt;
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ch3_config = chan[0].cfg;
  assign ch4_config = chan[1].cfg;
  assign ch3_capture_input = chan[0].filt_out;
  assign ch4_capture_input = chan[1].filt_out;
  assign ch3_capture_event = chan[0].cap;
  assign ch4_capture_event = chan[1].cap;
  assign ch3_channel_enable = enable_reg[0];
  assign ch4_channel_enable = enable_reg[1];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_sel_locked_ch4: assert property (enable_reg[1] |=>
    mode_reg[9:8] == $past(mode_reg[9:8]))
    else $error("ch4 select changed while enabled");
  a_reset_zero: assert property ($past(reset) |-> mode_reg == 16'h0000 &&
    ch3_config.direction_select == 2'h0)
    else $error("mode register not zero after reset");
  a_ch4_out_fields: assert property (mode_reg[9:8] == 2'h0 |=>
    ch4_config.compare_mode == $past(mode_reg[14:12]) &&
    ch4_config.clear_enable == $past(mode_reg[15]))
    else $error("ch4 compare fields wrong");
  a_ch3_out_fields: assert property (mode_reg[1:0] == 2'h0 |=>
    ch3_config.preload_enable == $past(mode_reg[3]) &&
    ch3_config.fast_enable == $past(mode_reg[2]))
    else $error("ch3 compare fields wrong");
  a_ch3_in_fields: assert property (mode_reg[1:0] != 2'h0 |=>
    ch3_config.input_filter == $past(mode_reg[7:4]) && ch3_config.compare_mode == 3'h0)
    else $error("ch3 input fields wrong");
  a_route_ch3: assert property (mode_reg[1:0] == 2'h2 |-> chan[0].raw == sync_b[1])
    else $error("ch3 not routed from input four");
  a_route_ch4: assert property (mode_reg[9:8] == 2'h2 |-> chan[1].raw == sync_b[0])
    else $error("ch4 not routed from input three");
  a_trig_gated: assert property (mode_reg[1:0] == 2'h3 &&
    !trigger_source_select_internal |-> chan[0].raw == 1'b0)
    else $error("trigger mapped while selector not internal");
  a_psc_clear: assert property (!enable_reg[0] |=> chan[0].psc_cnt == 3'h0)
    else $error("ch3 prescaler not cleared");
  a_psc_eighth: assert property (ch4_capture_event && $past(mode_reg[11:10]) == 2'h3
    |-> $past(chan[1].psc_cnt) == 3'h7)
    else $error("ch4 captured before eighth edge");
  a_filter_two: assert property ($changed(chan[0].filt_out) && $past(mode_reg[7:4]) == 4'h1
    && $past(mode_reg[7:4], 2) == 4'h1 && $past(mode_reg[1:0]) != 2'h0
    && $past(mode_reg[1:0], 2) != 2'h0 |-> $past(chan[0].raw, 2) == $past(chan[0].raw))
    else $error("ch3 filter flipped on one sample");
  a_ready_wait: assert property (access && !pready |=> pready) else $error("no ready");

  c_locked_write: cover property (wr && enable_reg[0] && paddr == 12'h01C);
  c_capture_eighth: cover property (ch4_capture_event && mode_reg[11:10] == 2'h3);
  c_trig_route: cover property (mode_reg[1:0] == 2'h3 && chan[0].raw);
  c_unmapped: cover property (pready && pslverr);

endmodule
`default_nettype wire

// file: test_timer_ch34_mode_config.sv
`timescale 1ns/10ps
`default_nettype none
module test_timer_ch34_mode_config;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic three, four, trig, trig_int, lvl3, lvl4, ev3, ev4, en3, en4;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  timer_ch34_pkg::ch_cfg_t cfg3, cfg4;
  int n_fail = 0;
  int n_checks = 0;
  int cnt3 = 0;
  int cnt4 = 0;

  timer_ch34_mode_config dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_three(three), .timer_input_four(four),
    .internal_trigger_signal(trig), .trigger_source_select_internal(trig_int),
    .ch3_config(cfg3), .ch4_config(cfg4), .ch3_capture_input(lvl3), .ch4_capture_input(lvl4),
    .ch3_capture_event(ev3), .ch4_capture_event(ev4), .ch3_channel_enable(en3),
    .ch4_channel_enable(en4));

  // ------------------------------------------------------------
  // clock and capture event counters
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // count capture pulses per channel
  always @(negedge ref_clk) begin
    if (ev3 === 1'b1) cnt3 <= cnt3 + 1;
    if (ev4 === 1'b1) cnt4 <= cnt4 + 1;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected decode of one channel byte
  function automatic timer_ch34_pkg::ch_cfg_t cfg_exp(input logic [7:0] b);
    timer_ch34_pkg::ch_cfg_t c;
    c = '0;
    c.direction_select = b[1:0];
    if (b[1:0] == 2'h0) begin
      c.clear_enable = b[7];
      c.compare_mode = b[6:4];
      c.preload_enable = b[3];
      c.fast_enable = b[2];
    end else begin
      c.input_filter = b[7:4];
      c.capture_prescale = b[3:2];
    end
    return c;
  endfunction

  // rising edges on input three, w cycles high and w low
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(posedge ref_clk);
      three <= 1'b1;
      repeat (w) @(posedge ref_clk);
      three <= 1'b0;
      repeat (w) @(posedge ref_clk);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(cfg3) | 32'(cfg4), 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check({rd[30:0], err}, 32'h0000_0001);
    $display("test done: reset and map");
  endtask

  task automatic t_fields(input logic [15:0] v);
    apb(1'b1, 12'h01C, {16'h0000, v});
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check(rd, {16'h0000, v});
    repeat (2) @(posedge ref_clk);
    check(32'(cfg3), 32'(cfg_exp(v[7:0])));
    check(32'(cfg4), 32'(cfg_exp(v[15:8])));
    $display("test done: fields %h", v);
  endtask

  task automatic t_lock;
    apb(1'b1, 12'h01C, 32'h0000_0000);
    apb(1'b1, 12'h020, 32'h0000_0100);
    apb(1'b1, 12'h01C, 32'h0000_0266);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check(rd, 32'h0000_0264);
    apb(1'b1, 12'h020, 32'h0000_1000);
    apb(1'b1, 12'h01C, 32'h0000_0001);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check(rd, 32'h0000_0201);
    check({en4, en3}, 32'h0000_0002);
    apb(1'b1, 12'h020, 32'h0000_0000);
    $display("test done: select lock");
  endtask

  task automatic t_route;
    logic [1:0] s;
    logic e3, e4;
    trig <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      s = (i / 2 > 3) ? 2'h3 : 2'(i / 2);
      trig_int <= (i / 2 != 4);
      three <= i[0];
      four <= ~i[0];
      apb(1'b1, 12'h01C, {22'h0, s, 6'h0, s});
      repeat (10) @(posedge ref_clk);
      e3 = (s == 2'h1) ? i[0] : (s == 2'h2) ? ~i[0] : (s == 2'h3) ? (i / 2 != 4) : 1'b0;
      e4 = (s == 2'h1) ? ~i[0] : (s == 2'h2) ? i[0] : (s == 2'h3) ? (i / 2 != 4) : 1'b0;
      check({lvl4, lvl3}, {30'h0, e4, e3});
    end
    three <= 1'b0;
    four <= 1'b0;
    trig <= 1'b0;
    $display("test done: routing");
  endtask

  task automatic t_psc;
    int c3, c4;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 12'h020, 32'h0000_0000);
      apb(1'b1, 12'h01C, {20'h0, 2'(p), 6'h20, 2'(p), 2'h1});
      apb(1'b1, 12'h020, 32'h0000_1100);
      c3 = cnt3;
      c4 = cnt4;
      pulse(8, 3);
      repeat (10) @(posedge ref_clk);
      check(cnt3 - c3, 8 >> p);
      check(cnt4 - c4, 8 >> p);
    end
    apb(1'b1, 12'h020, 32'h0000_0000);
    apb(1'b1, 12'h01C, 32'h0000_0605);
    apb(1'b1, 12'h020, 32'h0000_1100);
    c3 = cnt3;
    pulse(1, 3);
    apb(1'b1, 12'h020, 32'h0000_0000);
    apb(1'b1, 12'h020, 32'h0000_1100);
    pulse(1, 3);
    repeat (10) @(posedge ref_clk);
    check(cnt3 - c3, 0);
    pulse(1, 3);
    repeat (10) @(posedge ref_clk);
    check(cnt3 - c3, 1);
    $display("test done: prescaler");
  endtask

  task automatic t_filter;
    apb(1'b1, 12'h020, 32'h0000_0000);
    apb(1'b1, 12'h01C, 32'h0000_0031);
    repeat (12) @(posedge ref_clk);
    pulse(1, 4);
    repeat (8) @(posedge ref_clk);
    check(32'(lvl3), 32'h0000_0000);
    three <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(32'(lvl3), 32'h0000_0001);
    three <= 1'b0;
    repeat (20) @(posedge ref_clk);
    // code 1: two agreeing samples at full rate
    apb(1'b1, 12'h01C, 32'h0000_0011);
    pulse(1, 1);
    repeat (6) @(posedge ref_clk);
    check(32'(lvl3), 32'h0000_0000);
    three <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check(32'(lvl3), 32'h0000_0001);
    three <= 1'b0;
    $display("test done: filter");
  endtask

  // ------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset, then every scenario in turn
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, three, four, trig, trig_int} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_fields(16'hF4A8);
    t_fields(16'hA659);
    t_fields(16'h0BD7);
    t_lock();
    t_route();
    t_psc();
    t_filter();
    results();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
